// ===== rtl/pwil_top.sv
// Per-port wake enables, port interrupt status and mask, behind an AHB-Lite slave
//
// Contract
// - Magic packet wakes only when bit 2 set
// - Magic packet needs destination equal switch address
// - Link up wakes only when bit 1 set
// - Cable energy wakes only when bit 0 set
// - Link and energy wake only on PHY ports
// - Status bit 2 summarises timestamping, PHY ports
// - Status bit 1 summarises PHY interrupts, PHY ports
// - Status bit 0 set by rule-table counter entry
// - Toggling mask bit 0 clears rule-table status
// - Status bits read-only, one when detected, reset zero
// - Port mask bit zero enables, one disables; global mask bit one enables
// - Mask bits 2,1,0: timestamping, PHY, rule table
// - Rule source on all ports, others PHY only
// - Wake flags latched, readable, cleared by write
// - Wake enable and mask replicated per port, port-selected; switch address and global mask shared
`default_nettype none
`include "pwil_regs.svh"

module pwil_top #(
    parameter int NUM_PORTS = 7,
    parameter logic [NUM_PORTS-1:0] PHY_PORTS = 7'h1F
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Switch core events, one entry per port, port 1 at index 0
    input wire pwil_pkg::pwil_wake_t [NUM_PORTS-1:0] wake_evt,
    input wire logic [NUM_PORTS-1:0][47:0] magic_dst_addr,
    input wire pwil_pkg::pwil_src_t [NUM_PORTS-1:0] irq_src,
    // Outputs
    output logic power_wake_event_output,
    output logic [NUM_PORTS-1:0] port_irq,
    output logic irq
);

    // ==========================================================
    // Address decoding helpers

    function automatic logic pwil_hit(
        input logic [14:0] idx,
        input logic [2:0] port,
        input logic [11:0] off
    );
        return (idx[14:12] == port) && (idx[11:0] == off);
    endfunction : pwil_hit

    // ==========================================================
    // Bus state

    logic wr_pend_ff;
    logic [14:0] wr_idx_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    logic [47:0] mac_ff;
    logic [NUM_PORTS-1:0] irq_stat_ff;
    logic [NUM_PORTS-1:0] irq_mask_ff;
    logic irq_ff;
    logic pme_ff;
    logic [NUM_PORTS-1:0] port_irq_ff;

    wire addr_take = hsel && htrans[1] && hready;
    wire addr_in_map = (haddr[31:17] == 15'h0000);
    wire [14:0] a_idx = haddr[16:2];
    wire rd_take = addr_take && !hwrite;
    wire wr_take = addr_take && hwrite && addr_in_map;

    // ==========================================================
    // Global write strobes (data phase)

    wire we_mac_lo = wr_pend_ff && pwil_hit(wr_idx_ff, `PWIL_GLOBAL_PORT, `PWIL_OFF_MAC_LO);
    wire we_mac_hi = wr_pend_ff && pwil_hit(wr_idx_ff, `PWIL_GLOBAL_PORT, `PWIL_OFF_MAC_HI);
    wire we_irq_stat = wr_pend_ff &&
        pwil_hit(wr_idx_ff, `PWIL_GLOBAL_PORT, `PWIL_OFF_IRQ_STAT);
    wire we_irq_mask = wr_pend_ff &&
        pwil_hit(wr_idx_ff, `PWIL_GLOBAL_PORT, `PWIL_OFF_IRQ_MASK);

    // ==========================================================
    // Per-port copies

    wire [31:0] rd_port [NUM_PORTS];
    wire [NUM_PORTS-1:0] pme_port;
    wire [NUM_PORTS-1:0] port_irq_nxt;

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : gen_port
            logic [2:0] wake_flag_ff;
            logic [2:0] wake_en_ff;
            logic [2:0] stat_ff;
            logic [2:0] mask_ff;

            localparam logic [2:0] PNUM = 3'(p + 1);
            localparam logic IS_PHY = PHY_PORTS[p];

            // Write strobes for this port's copy
            wire we_flag = wr_pend_ff &&
                pwil_hit(wr_idx_ff, PNUM, `PWIL_OFF_WAKE_FLAG);
            wire we_en = wr_pend_ff && pwil_hit(wr_idx_ff, PNUM, `PWIL_OFF_WAKE_EN);
            wire we_mask = wr_pend_ff && pwil_hit(wr_idx_ff, PNUM, `PWIL_OFF_PORT_MASK);

            // Wake detection
            wire magic_ok = wake_evt[p].magic && (magic_dst_addr[p] == mac_ff);
            wire link_ok = wake_evt[p].link && IS_PHY;
            wire energy_ok = wake_evt[p].energy && IS_PHY;
            wire [2:0] wake_set = {magic_ok, link_ok, energy_ok};
            wire [2:0] wake_clr = we_flag ? hwdata[2:0] : 3'h0;
            wire [2:0] nxt_wake_flag = (wake_flag_ff & ~wake_clr) | wake_set;

            // Link and energy enables only count on PHY ports
            wire [2:0] en_eff = {wake_en_ff[`PWIL_BIT_MAGIC],
                                 wake_en_ff[`PWIL_BIT_LINK] && IS_PHY,
                                 wake_en_ff[`PWIL_BIT_ENERGY] && IS_PHY};
            assign pme_port[p] = |(wake_flag_ff & en_eff);

            // Interrupt sources
            wire rule_toggle = we_mask &&
                (hwdata[`PWIL_BIT_RULE] != mask_ff[`PWIL_BIT_RULE]);
            wire nxt_rule = (stat_ff[`PWIL_BIT_RULE] && !rule_toggle) ||
                irq_src[p].rule;
            wire [2:0] nxt_stat = {irq_src[p].ptp && IS_PHY,
                                   irq_src[p].phy && IS_PHY,
                                   nxt_rule};
            assign port_irq_nxt[p] = |(stat_ff & ~mask_ff);

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    wake_flag_ff <= `PWIL_RST_FIELD;
                    wake_en_ff <= `PWIL_RST_FIELD;
                    stat_ff <= `PWIL_RST_FIELD;
                    mask_ff <= `PWIL_RST_FIELD;
                end else begin
                    wake_flag_ff <= nxt_wake_flag;
                    stat_ff <= nxt_stat;
                    if (we_en) begin
                        wake_en_ff <= hwdata[2:0];
                    end
                    if (we_mask) begin
                        mask_ff <= hwdata[2:0];
                    end
                end
            end

            // Read value of this port's copy
            wire hit_flag = pwil_hit(a_idx, PNUM, `PWIL_OFF_WAKE_FLAG);
            wire hit_en = pwil_hit(a_idx, PNUM, `PWIL_OFF_WAKE_EN);
            wire hit_stat = pwil_hit(a_idx, PNUM, `PWIL_OFF_PORT_STAT);
            wire hit_mask = pwil_hit(a_idx, PNUM, `PWIL_OFF_PORT_MASK);
            assign rd_port[p] = hit_flag ? {29'h0000_0000, wake_flag_ff} :
                                hit_en ? {29'h0000_0000, wake_en_ff} :
                                hit_stat ? {29'h0000_0000, stat_ff} :
                                hit_mask ? {29'h0000_0000, mask_ff} :
                                32'h0000_0000;
        end
    endgenerate

    // ==========================================================
    // Read data selection

    wire hit_mac_lo = pwil_hit(a_idx, `PWIL_GLOBAL_PORT, `PWIL_OFF_MAC_LO);
    wire hit_mac_hi = pwil_hit(a_idx, `PWIL_GLOBAL_PORT, `PWIL_OFF_MAC_HI);
    wire hit_irq_stat = pwil_hit(a_idx, `PWIL_GLOBAL_PORT, `PWIL_OFF_IRQ_STAT);
    wire hit_irq_mask = pwil_hit(a_idx, `PWIL_GLOBAL_PORT, `PWIL_OFF_IRQ_MASK);
    wire [31:0] rd_global = hit_mac_lo ? mac_ff[31:0] :
                            hit_mac_hi ? {16'h0000, mac_ff[47:32]} :
                            hit_irq_stat ? 32'(irq_stat_ff) :
                            hit_irq_mask ? 32'(irq_mask_ff) :
                            32'h0000_0000;

    logic [31:0] rd_ports_or;
    always_comb begin
        rd_ports_or = 32'h0000_0000;
        for (int i = 0; i < NUM_PORTS; i++) begin
            rd_ports_or = rd_ports_or | rd_port[i];
        end
    end

    // Unmapped addresses read as zero
    wire [31:0] rd_data = addr_in_map ? (rd_ports_or | rd_global) : 32'h0000_0000;

    // ==========================================================
    // AHB-Lite slave: no wait states, always OKAY

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 15'h0000;
            hrdata_ff <= 32'h0000_0000;
            hreadyout_ff <= 1'b0;
            hresp_ff <= 1'b0;
        end else begin
            wr_pend_ff <= wr_take;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
            if (wr_take) begin
                wr_idx_ff <= a_idx;
            end
            if (rd_take) begin
                hrdata_ff <= rd_data;
            end
        end
    end

    // ==========================================================
    // Switch address, global interrupt status and mask, outputs

    wire [NUM_PORTS-1:0] irq_clr = we_irq_stat ? hwdata[NUM_PORTS-1:0] : '0;
    wire [NUM_PORTS-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | port_irq_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mac_ff <= `PWIL_RST_MAC;
            irq_stat_ff <= '0;
            irq_mask_ff <= '0;
            irq_ff <= 1'b0;
            pme_ff <= 1'b0;
            port_irq_ff <= '0;
        end else begin
            if (we_mac_lo) begin
                mac_ff[31:0] <= hwdata;
            end
            if (we_mac_hi) begin
                mac_ff[47:32] <= hwdata[15:0];
            end
            if (we_irq_mask) begin
                irq_mask_ff <= hwdata[NUM_PORTS-1:0];
            end
            irq_stat_ff <= nxt_irq_stat;
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
            pme_ff <= |pme_port;
            port_irq_ff <= port_irq_nxt;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign power_wake_event_output = pme_ff;
    assign port_irq = port_irq_ff;
    assign irq = irq_ff;

endmodule : pwil_top
`default_nettype wire

// ===== rtl/pwil_regs.svh
// Register indices, field positions and reset values of the port wake and interrupt block
`ifndef PWIL_REGS_SVH
`define PWIL_REGS_SVH

// ==========================================================
// Register indices inside a port space (byte address = 4 * index)
`define PWIL_OFF_WAKE_FLAG 12'h013
`define PWIL_OFF_WAKE_EN 12'h017
`define PWIL_OFF_PORT_STAT 12'h01B
`define PWIL_OFF_PORT_MASK 12'h01F

// ==========================================================
// Global register indices (port field 0)
`define PWIL_OFF_MAC_LO 12'h100
`define PWIL_OFF_MAC_HI 12'h101
`define PWIL_OFF_IRQ_STAT 12'h110
`define PWIL_OFF_IRQ_MASK 12'h111
`define PWIL_GLOBAL_PORT 3'h0

// ==========================================================
// Field positions
`define PWIL_BIT_MAGIC 2
`define PWIL_BIT_LINK 1
`define PWIL_BIT_ENERGY 0
`define PWIL_BIT_PTP 2
`define PWIL_BIT_PHY 1
`define PWIL_BIT_RULE 0

// ==========================================================
// Reset values
`define PWIL_RST_FIELD 3'h0
`define PWIL_RST_MAC 48'h0000_0000_0000

`endif

// ===== rtl/pwil_pkg.sv
// Types shared by the port wake and interrupt block
`default_nettype none
package pwil_pkg;

    // Per-port wake detection pulses
    typedef struct packed {
        logic magic;
        logic link;
        logic energy;
    } pwil_wake_t;

    // Per-port interrupt sources
    typedef struct packed {
        logic ptp;
        logic phy;
        logic rule;
    } pwil_src_t;

endpackage : pwil_pkg
`default_nettype wire

// ===== verif/pwil_top_checker.sv
// Port relations of the port wake and interrupt block
`default_nettype none
module pwil_top_checker #(
    parameter int NUM_PORTS = 7,
    parameter logic [NUM_PORTS-1:0] PHY_PORTS = 7'h1F
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus request
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    // Events and outputs
    input wire pwil_pkg::pwil_wake_t [NUM_PORTS-1:0] wake_evt,
    input wire pwil_pkg::pwil_src_t [NUM_PORTS-1:0] irq_src,
    input wire logic power_wake_event_output,
    input wire logic [NUM_PORTS-1:0] port_irq,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_req, recent_wr;
    logic [7:0] wr_hist_ff, nxt_wr_hist;
    assign wr_req = hsel & htrans[1] & hwrite & hready;
    assign nxt_wr_hist = {wr_hist_ff[6:0], wr_req};
    assign recent_wr = |wr_hist_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_hist_ff <= 8'h00;
        else wr_hist_ff <= nxt_wr_hist;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Port 7 quiet: no rule pulse and no write
    sequence s_quiet7;
        (!irq_src[6].rule && !wr_req)[*5];
    endsequence
    property p_wake_rise;
        $rose(power_wake_event_output) |->
            $past(|wake_evt[4:0] || wake_evt[5].magic || wake_evt[6].magic, 2) || recent_wr;
    endproperty
    a_wake_rise: assert property (p_wake_rise)
        else $error("wake output rose without cause");
    property p_wake_fall;
        $fell(power_wake_event_output) |-> recent_wr;
    endproperty
    a_wake_fall: assert property (p_wake_fall)
        else $error("wake output fell without write");
    property p_irq_rise;
        $rose(port_irq[0]) |-> $past(|irq_src[0], 2) || recent_wr;
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("port 1 interrupt rose without source");
    property p_irq_fall;
        $fell(port_irq[0]) |-> recent_wr || $past(irq_src[0].ptp || irq_src[0].phy, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("port 1 interrupt fell without cause");
    property p_nophy_rise;
        $rose(port_irq[5]) |-> $past(irq_src[5].rule, 2) || recent_wr;
    endproperty
    a_nophy_rise: assert property (p_nophy_rise)
        else $error("port 6 interrupt rose without rule pulse");
    property p_quiet7;
        s_quiet7 |-> !$rose(port_irq[6]);
    endproperty
    a_quiet7: assert property (p_quiet7)
        else $error("port 7 interrupt rose from a phy-only source");
    property p_rule_fall;
        $fell(port_irq[5]) |-> recent_wr;
    endproperty
    a_rule_fall: assert property (p_rule_fall)
        else $error("port 6 rule status cleared without mask write");
    property p_gl_rise;
        $rose(irq) |-> $past(|port_irq, 2) || recent_wr;
    endproperty
    a_gl_rise: assert property (p_gl_rise)
        else $error("global interrupt rose without port interrupt");
endmodule : pwil_top_checker
bind pwil_top pwil_top_checker #(.NUM_PORTS(NUM_PORTS), .PHY_PORTS(PHY_PORTS)) chk_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .wake_evt(wake_evt), .irq_src(irq_src), .irq(irq),
    .power_wake_event_output(power_wake_event_output), .port_irq(port_irq));
`default_nettype wire

// ===== verif/pwil_evt_src.sv
// Model of the switch core raising wake and interrupt events
`default_nettype none
module pwil_evt_src (
    // Clock
    input wire logic clk,
    // Event lines, port 1 at index 0
    output var pwil_pkg::pwil_wake_t [6:0] wake_evt,
    output var logic [6:0][47:0] magic_dst_addr,
    output var pwil_pkg::pwil_src_t [6:0] irq_src
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wake_evt = '0;
        magic_dst_addr = '0;
        irq_src = '0;
    end
    // One-cycle pulse; the address is scrambled once no longer valid
    task automatic wake(input int p, input pwil_pkg::pwil_wake_t w, input logic [47:0] da);
        wake_evt[p] <= w;
        magic_dst_addr[p] <= da;
        @(posedge clk);
        wake_evt[p] <= 3'h0;
        magic_dst_addr[p] <= ~da;
    endtask : wake
    task automatic rule(input int p);
        irq_src[p].rule <= 1'b1;
        @(posedge clk);
        irq_src[p].rule <= 1'b0;
    endtask : rule
    task automatic lvl(input int p, input logic ptp, input logic phy);
        irq_src[p].ptp <= ptp;
        irq_src[p].phy <= phy;
    endtask : lvl
endmodule : pwil_evt_src
`default_nettype wire

// ===== verif/pwil_top_tb.sv
// Self-checking bench for the port wake and interrupt block
`default_nettype none
`include "pwil_regs.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module pwil_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout, hresp, pweo, irq;
    logic [6:0] port_irq;
    pwil_pkg::pwil_wake_t [6:0] wake_evt;
    pwil_pkg::pwil_src_t [6:0] irq_src;
    logic [6:0][47:0] magic_dst_addr;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc_cnt = 0;
    localparam logic [47:0] MAC = 48'hA1B2_C3D4_E5F6;
    pwil_top pwil_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wake_evt(wake_evt),
        .magic_dst_addr(magic_dst_addr), .irq_src(irq_src), .power_wake_event_output(pweo),
        .port_irq(port_irq), .irq(irq));
    pwil_evt_src pwil_evt_src_i (.clk(hclk), .wake_evt(wake_evt),
        .magic_dst_addr(magic_dst_addr), .irq_src(irq_src));
    always #5 hclk = ~hclk;
    function automatic logic [31:0] pa(input int p, input logic [11:0] o);
        return {15'h0000, 3'(p), o, 2'h0};
    endfunction : pa
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        `CHK(n, e, q)
    endtask : rdc
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : cyc
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    always @(posedge hclk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 3000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        cyc(2);
        for (int p = 1; p < 8; p++) rdc("stat_rst", pa(p, `PWIL_OFF_PORT_STAT), 0);
        rdc("mask_rst", pa(1, `PWIL_OFF_PORT_MASK), 0);
        `CHK("hresp", 1'b0, hresp)
        wr(pa(0, `PWIL_OFF_MAC_LO), MAC[31:0]);
        wr(pa(0, `PWIL_OFF_MAC_HI), {16'h0000, MAC[47:32]});
        wr(pa(1, `PWIL_OFF_WAKE_EN), 32'h7);
        rdc("en3", pa(3, `PWIL_OFF_WAKE_EN), 0);
        rdc("unmapped", 32'h0010_0000, 0);
        pwil_evt_src_i.wake(0, 3'h4, ~MAC);
        cyc(3);
        `CHK("pweo_badaddr", 1'b0, pweo)
        pwil_evt_src_i.wake(0, 3'h4, MAC);
        cyc(3);
        `CHK("pweo_magic", 1'b1, pweo)
        rdc("flags1", pa(1, `PWIL_OFF_WAKE_FLAG), 4);
        wr(pa(1, `PWIL_OFF_WAKE_FLAG), 32'h4);
        cyc(3);
        `CHK("pweo_clr", 1'b0, pweo)
        for (int b = 0; b < 2; b++) begin
            pwil_evt_src_i.wake(1, 3'h1 << b, MAC);
            cyc(3);
            `CHK("pweo_off", 1'b0, pweo)
            wr(pa(2, `PWIL_OFF_WAKE_EN), 32'h1 << b);
            cyc(3);
            `CHK("pweo_on", 1'b1, pweo)
            wr(pa(2, `PWIL_OFF_WAKE_FLAG), 32'h7);
            wr(pa(2, `PWIL_OFF_WAKE_EN), 0);
        end
        wr(pa(6, `PWIL_OFF_WAKE_EN), 32'h7);
        pwil_evt_src_i.wake(5, 3'h3, MAC);
        cyc(3);
        `CHK("pweo_nophy", 1'b0, pweo)
        rdc("flags6", pa(6, `PWIL_OFF_WAKE_FLAG), 0);
        pwil_evt_src_i.lvl(0, 1'b0, 1'b1);
        cyc(3);
        `CHK("irq1_phy", 1'b1, port_irq[0])
        rdc("stat1", pa(1, `PWIL_OFF_PORT_STAT), 2);
        wr(pa(1, `PWIL_OFF_PORT_STAT), 32'h7);
        wr(pa(1, `PWIL_OFF_PORT_MASK), 32'h2);
        cyc(2);
        `CHK("irq1_masked", 1'b0, port_irq[0])
        pwil_evt_src_i.lvl(0, 1'b1, 1'b1);
        cyc(3);
        rdc("stat1_ro", pa(1, `PWIL_OFF_PORT_STAT), 6);
        `CHK("irq1_ptp", 1'b1, port_irq[0])
        wr(pa(0, `PWIL_OFF_IRQ_MASK), 32'h1);
        cyc(4);
        `CHK("irq_on", 1'b1, irq)
        wr(pa(1, `PWIL_OFF_PORT_MASK), 32'h7);
        rdc("mask1", pa(1, `PWIL_OFF_PORT_MASK), 7);
        cyc(3);
        wr(pa(0, `PWIL_OFF_IRQ_STAT), 32'h7F);
        cyc(4);
        `CHK("irq_off", 1'b0, irq)
        for (int p = 5; p < 7; p++) begin
            pwil_evt_src_i.lvl(p, 1'b1, 1'b1);
            cyc(3);
            pwil_evt_src_i.rule(p);
            cyc(3);
            rdc("stat_rule", pa(p + 1, `PWIL_OFF_PORT_STAT), 1);
            `CHK("irq_rule", 1'b1, port_irq[p])
            wr(pa(p + 1, `PWIL_OFF_PORT_MASK), 32'h1);
            cyc(2);
            rdc("stat_tog", pa(p + 1, `PWIL_OFF_PORT_STAT), 0);
            wr(pa(p + 1, `PWIL_OFF_PORT_MASK), 0);
            cyc(2);
            `CHK("irq_tog", 1'b0, port_irq[p])
        end
        final_report();
    end
endmodule : pwil_top_tb
`default_nettype wire
